//--- verilog/redriver_global_config_regs.vh
// Offsets, field positions, masks and reset values of the global configuration registers
`ifndef REDRIVER_GLOBAL_CONFIG_REGS_VH
`define REDRIVER_GLOBAL_CONFIG_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define MISC_SETTINGS_OFF       8'h0a
`define DATA_SLEW_OFF           8'h0b
`define CLOCK_SLEW_OFF          8'h0c
`define DRIVE_SETTINGS_OFF      8'h0d
`define EQ_CHOICE_OFF           8'h0e

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MISC_SETTINGS_RST       8'h08
`define DATA_SLEW_RST           8'h34
`define CLOCK_SLEW_RST          8'h71
`define DRIVE_SETTINGS_RST      8'h22
`define EQ_CHOICE_RST           8'h3f

// ---------------------------------------------------------------
// Writable bit masks (read-only reserved bits are zero)
// ---------------------------------------------------------------
`define DATA_SLEW_WMASK         8'h77
`define CLOCK_SLEW_WMASK        8'h77

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LANE_SWAP_BIT           7
`define RX_LOAD_DISABLE_BIT     5
`define HOTPLUG_STYLE_BIT       4
`define SNOOP_OFF_BIT           2
`define LOW_EDGE_HI             6
`define LOW_EDGE_LO             4
`define HIGH_EDGE_HI            2
`define HIGH_EDGE_LO            0
`define CLOCK_EDGE_HI           2
`define CLOCK_EDGE_LO           0
`define LINEAR_BIT              7
`define COUPLING_BIT            6
`define DC_GAIN_HI              5
`define DC_GAIN_LO              4
`define AUTO_POLICY_BIT         3
`define BYPASS_EN_BIT           2
`define TX_LOAD_HI              1
`define TX_LOAD_LO              0
`define LOW_EQ_PICK_HI          5
`define LOW_EQ_PICK_LO          4
`define HIGH_EQ_PICK_HI         3
`define HIGH_EQ_PICK_LO         2

// ---------------------------------------------------------------
// Field codes
// ---------------------------------------------------------------
`define DC_GAIN_ZERO_DB         2'h2
`define LOAD_NONE               2'h0
`define LOAD_300                2'h1
`define LOAD_AUTO               2'h2
`define LOAD_100                2'h3
`define EQ_PICK_LOW             2'h0
`define EQ_PICK_HIGH            2'h1
`define EQ_PICK_AUTO            2'h2

`endif

//--- verilog/redriver_global_config.v
// Global configuration registers of the redriver with their serial-bus target
//
// Contract
// - Lane swap bit set swaps input and output lanes; clear swaps none; resets 0.
// - Receive load disable set kills termination; else termination follows hotplug input.
// - Hotplug output style bit: 0 push-pull, 1 open-drain; resets 0.
// - Snoop control 0 lets device snoop link rate; 1 stops snooping.
// - Data slew bits 6-4 set low-rate data edge speed; reset 3.
// - Data slew bits 2-0 set high-rate data edge speed; reset 4.
// - Clock slew bits 2-0 set clock lane edge speed; reset 1.
// - Drive bit 7 picks limited (0) or linear (1) style; reset 0.
// - Drive bit 6 picks DC (0) or AC (1) coupling with supply loads.
// - DC gain codes 0,1 give -3 dB, 2 gives 0 dB, 3 gives +1 dB.
// - Auto load at low rate: policy 0 none up to 165, 300 above 225.
// - Bypass equalizer only if enabled, gain code 2 and equalization zero.
// - Load field: 0 none, 1 300 ohm, 2 automatic, 3 100 ohm.
// - Low-rate equalizer pick: 0 low, 1 high, 2 auto, 3 reserved; reset 3.
// - High-rate equalizer pick uses the same encoding at bits 3-2.
// - Equalizer picks touch data lanes only; clock lane always uses low version.
// - Soft reset pulse returns every field here to its reset value.
`timescale 1ns/1ps
`include "redriver_global_config_regs.vh"

module redriver_global_config #(
  parameter [6:0] DEVICE_ADDR = 7'h2c
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       soft_reset,
  input  wire       hotplug_in_pin,
  output reg        hotplug_out_pin,
  output reg        hotplug_out_oe,
  input  wire       link_high_rate_snooped,
  input  wire       link_high_rate_written,
  input  wire       tmds_clk_over_225,
  input  wire       eq_setting_zero,
  output wire       lane_swap,
  output reg        rx_term_enable,
  output wire       snoop_enable,
  output wire [2:0] low_rate_edge_speed,
  output wire [2:0] high_rate_edge_speed,
  output wire [2:0] clock_edge_speed,
  output wire       linear_style_select,
  output wire       tx_coupling_select,
  output reg  [1:0] dc_gain_level,
  output reg  [1:0] tx_load,
  output reg        data_eq_high_rate,
  output wire       clock_eq_high_rate,
  output reg        equalizer_bypass
);

  // ---------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire      rst_n;
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg [1:0] hpd_sync_q;
  reg       scl_d_q;
  reg       sda_d_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      hpd_sync_q <= 2'h0;
      scl_d_q    <= 1'b1;
      sda_d_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      hpd_sync_q <= {hpd_sync_q[0], hotplug_in_pin};
      scl_d_q    <= scl_sync_q[1];
      sda_d_q    <= sda_sync_q[1];
    end
  end

  wire scl_s   = scl_sync_q[1];
  wire sda_s   = sda_sync_q[1];
  wire hpd_s   = hpd_sync_q[1];
  wire scl_rise = scl_s & ~scl_d_q;
  wire scl_fall = ~scl_s & scl_d_q;
  wire start_c = scl_s & scl_d_q & sda_d_q & ~sda_s;
  wire stop_c  = scl_s & scl_d_q & ~sda_d_q & sda_s;

  // ---------------------------------------------------------------
  // Serial target state machine
  // ---------------------------------------------------------------
  localparam [8:0] ST_IDLE     = 9'h001;
  localparam [8:0] ST_ADDR     = 9'h002;
  localparam [8:0] ST_ADDR_ACK = 9'h004;
  localparam [8:0] ST_PTR      = 9'h008;
  localparam [8:0] ST_PTR_ACK  = 9'h010;
  localparam [8:0] ST_WR       = 9'h020;
  localparam [8:0] ST_WR_ACK   = 9'h040;
  localparam [8:0] ST_RD       = 9'h080;
  localparam [8:0] ST_RD_ACK   = 9'h100;

  reg [8:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg       rw_q;
  reg       mack_q;
  reg       sda_low_q;
  reg       wr_en_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg [7:0] rd_data;

  // Register file
  reg [7:0] misc_q;
  reg [7:0] dslew_q;
  reg [7:0] cslew_q;
  reg [7:0] drive_q;
  reg [7:0] eqsel_q;

  // Unmapped offsets read as zero, so the host sees no stale data
  always @* begin
    case (ptr_q)
      `MISC_SETTINGS_OFF:  rd_data = misc_q;
      `DATA_SLEW_OFF:      rd_data = dslew_q;
      `CLOCK_SLEW_OFF:     rd_data = cslew_q;
      `DRIVE_SETTINGS_OFF: rd_data = drive_q;
      `EQ_CHOICE_OFF:      rd_data = eqsel_q;
      default:             rd_data = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
      sda_low_q <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (start_c) begin
        state_q   <= ST_ADDR;
        cnt_q     <= 4'h0;
        sda_low_q <= 1'b0;
      end else if (stop_c) begin
        state_q   <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q   <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                if (shift_q[7:1] == DEVICE_ADDR) begin
                  state_q   <= ST_ADDR_ACK;
                  rw_q      <= shift_q[0];
                  sda_low_q <= 1'b1;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_PTR) begin
                ptr_q     <= shift_q;
                state_q   <= ST_PTR_ACK;
                sda_low_q <= 1'b1;
              end else begin
                wr_en_q   <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                state_q   <= ST_WR_ACK;
                sda_low_q <= 1'b1;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q      <= rd_data;
                sda_low_q <= ~rd_data[7];
                state_q   <= ST_RD;
              end else begin
                sda_low_q <= 1'b0;
                state_q   <= ST_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_WR_ACK: begin
            if (scl_fall) begin
              sda_low_q <= 1'b0;
              cnt_q     <= 4'h0;
              state_q   <= ST_WR;
              if (state_q == ST_WR_ACK) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == 4'h8) begin
                sda_low_q <= 1'b0;
                ptr_q     <= ptr_q + 8'h01;
                state_q   <= ST_RD_ACK;
              end else begin
                sda_low_q <= ~tx_q[3'h7 - cnt_q[2:0]];
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (mack_q) begin
                tx_q      <= rd_data;
                sda_low_q <= ~rd_data[7];
                state_q   <= ST_RD;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q   <= ST_IDLE;
            sda_low_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_low_q;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_q  <= `MISC_SETTINGS_RST;
      dslew_q <= `DATA_SLEW_RST;
      cslew_q <= `CLOCK_SLEW_RST;
      drive_q <= `DRIVE_SETTINGS_RST;
      eqsel_q <= `EQ_CHOICE_RST;
    end else if (soft_reset) begin
      misc_q  <= `MISC_SETTINGS_RST;
      dslew_q <= `DATA_SLEW_RST;
      cslew_q <= `CLOCK_SLEW_RST;
      drive_q <= `DRIVE_SETTINGS_RST;
      eqsel_q <= `EQ_CHOICE_RST;
    end else if (wr_en_q) begin
      case (wr_addr_q)
        `MISC_SETTINGS_OFF:  misc_q  <= wr_data_q;
        `DATA_SLEW_OFF:      dslew_q <= wr_data_q & `DATA_SLEW_WMASK;
        `CLOCK_SLEW_OFF:     cslew_q <= wr_data_q & `CLOCK_SLEW_WMASK;
        `DRIVE_SETTINGS_OFF: drive_q <= wr_data_q;
        `EQ_CHOICE_OFF:      eqsel_q <= wr_data_q;
        default:             misc_q  <= misc_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  assign lane_swap            = misc_q[`LANE_SWAP_BIT];
  assign snoop_enable         = ~misc_q[`SNOOP_OFF_BIT];
  assign low_rate_edge_speed  = dslew_q[`LOW_EDGE_HI:`LOW_EDGE_LO];
  assign high_rate_edge_speed = dslew_q[`HIGH_EDGE_HI:`HIGH_EDGE_LO];
  assign clock_edge_speed     = cslew_q[`CLOCK_EDGE_HI:`CLOCK_EDGE_LO];
  assign linear_style_select  = drive_q[`LINEAR_BIT];
  assign tx_coupling_select   = drive_q[`COUPLING_BIT];
  assign clock_eq_high_rate   = 1'b0;

  // Written rate stands in only while snooping is off
  wire       high_rate = snoop_enable ? link_high_rate_snooped : link_high_rate_written;
  wire [1:0] gain_code = drive_q[`DC_GAIN_HI:`DC_GAIN_LO];
  wire [1:0] load_code = drive_q[`TX_LOAD_HI:`TX_LOAD_LO];
  wire [1:0] eq_pick   = high_rate ? eqsel_q[`HIGH_EQ_PICK_HI:`HIGH_EQ_PICK_LO]
                                   : eqsel_q[`LOW_EQ_PICK_HI:`LOW_EQ_PICK_LO];
  reg  [1:0] load_d;
  reg        eq_d;

  always @* begin
    case (load_code)
      `LOAD_NONE: load_d = `LOAD_NONE;
      `LOAD_300:  load_d = `LOAD_300;
      `LOAD_AUTO: begin
        if (high_rate) begin
          load_d = `LOAD_300;
        end else if (drive_q[`AUTO_POLICY_BIT] || tmds_clk_over_225) begin
          load_d = `LOAD_300;
        end else begin
          load_d = `LOAD_NONE;
        end
      end
      default:    load_d = `LOAD_100;
    endcase
    case (eq_pick)
      `EQ_PICK_HIGH: eq_d = 1'b1;
      `EQ_PICK_AUTO: eq_d = link_high_rate_snooped;
      default:       eq_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_term_enable    <= 1'b0;
      hotplug_out_pin   <= 1'b0;
      hotplug_out_oe    <= 1'b0;
      dc_gain_level     <= `DC_GAIN_ZERO_DB;
      tx_load           <= `LOAD_NONE;
      data_eq_high_rate <= 1'b0;
      equalizer_bypass  <= 1'b0;
    end else begin
      rx_term_enable <= ~misc_q[`RX_LOAD_DISABLE_BIT] & hpd_s;
      if (misc_q[`HOTPLUG_STYLE_BIT]) begin
        hotplug_out_pin <= 1'b0;
        hotplug_out_oe  <= ~hpd_s;
      end else begin
        hotplug_out_pin <= hpd_s;
        hotplug_out_oe  <= 1'b1;
      end
      // Codes 0 and 1 give the same gain, so fold 1 onto 0
      dc_gain_level     <= (gain_code == 2'h1) ? 2'h0 : gain_code;
      tx_load           <= load_d;
      data_eq_high_rate <= eq_d;
      equalizer_bypass  <= drive_q[`BYPASS_EN_BIT] & (gain_code == `DC_GAIN_ZERO_DB)
                           & eq_setting_zero;
    end
  end

endmodule

//--- bench/redriver_global_config_asserts.sv
// Concurrent checks on the outputs of the global configuration registers
`timescale 1ns/1ps
module redriver_global_config_asserts (
  input wire       clk,
  input wire       arst_n,
  input wire       soft_reset,
  input wire       hotplug_in_pin,
  input wire       hotplug_out_pin,
  input wire       hotplug_out_oe,
  input wire       eq_setting_zero,
  input wire       lane_swap,
  input wire       rx_term_enable,
  input wire       snoop_enable,
  input wire [2:0] low_rate_edge_speed,
  input wire [2:0] high_rate_edge_speed,
  input wire [2:0] clock_edge_speed,
  input wire       linear_style_select,
  input wire       tx_coupling_select,
  input wire [1:0] dc_gain_level,
  input wire [1:0] tx_load,
  input wire       data_eq_high_rate,
  input wire       clock_eq_high_rate,
  input wire       equalizer_bypass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_gain_fold: assert property (dc_gain_level != 2'h1)
    else $error("gain code 1 not folded");
  a_load_code: assert property (tx_load != 2'h2)
    else $error("auto load code reached the lanes");
  a_clock_eq: assert property (!clock_eq_high_rate)
    else $error("clock lane left the low equalizer");
  a_bypass_cause: assert property (equalizer_bypass |-> dc_gain_level == 2'h2 && $past(eq_setting_zero))
    else $error("bypass without its conditions");
  a_rxterm_hpd: assert property (rx_term_enable |-> $past(hotplug_in_pin, 3))
    else $error("termination on with hotplug low");
  a_hpd_drive: assert property (hotplug_out_pin |-> hotplug_out_oe && $past(hotplug_in_pin, 3))
    else $error("hotplug out high without cause");
  // Open-drain release only when the input was high three edges back
  a_hpd_release: assert property (!hotplug_out_oe && $past(arst_n, 3) |-> $past(hotplug_in_pin, 3))
    else $error("hotplug out released wrongly");
  a_soft_direct: assert property (soft_reset |=> !lane_swap && snoop_enable && low_rate_edge_speed == 3'h3
    && high_rate_edge_speed == 3'h4 && clock_edge_speed == 3'h1 && !linear_style_select && !tx_coupling_select)
    else $error("soft reset missed a field");
  a_soft_derived: assert property (soft_reset |-> ##2 dc_gain_level == 2'h2 && !data_eq_high_rate)
    else $error("soft reset missed a derived output");
endmodule

bind redriver_global_config redriver_global_config_asserts chk (
  .clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .hotplug_in_pin(hotplug_in_pin),
  .hotplug_out_pin(hotplug_out_pin), .hotplug_out_oe(hotplug_out_oe), .eq_setting_zero(eq_setting_zero),
  .lane_swap(lane_swap), .rx_term_enable(rx_term_enable), .snoop_enable(snoop_enable),
  .low_rate_edge_speed(low_rate_edge_speed), .high_rate_edge_speed(high_rate_edge_speed),
  .clock_edge_speed(clock_edge_speed), .linear_style_select(linear_style_select),
  .tx_coupling_select(tx_coupling_select), .dc_gain_level(dc_gain_level), .tx_load(tx_load),
  .data_eq_high_rate(data_eq_high_rate), .clock_eq_high_rate(clock_eq_high_rate),
  .equalizer_bypass(equalizer_bypass));

//--- bench/i2c_host_model.sv
// Serial-bus host model that configures the register block
`timescale 1ns/1ps
module i2c_host_model #(
  parameter [6:0] ADDR = 7'h2c
) (
  input  wire clk,
  input  wire sda_oe,
  output reg  scl,
  output wire sda_line
);
  reg sda_q;
  // Pull-up on the line: a released line reads high
  assign sda_line = sda_q & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_q = 1'b1;
  end
  task w(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves mid-way through the low phase, clear of synchroniser skew
  task bit_io(input b, output r);
    begin
      scl <= 1'b0;
      w(4);
      sda_q <= b;
      w(4);
      scl <= 1'b1;
      w(8);
      r = sda_line;
    end
  endtask
  task frame(input a, input b);
    reg r;
    begin
      bit_io(a, r);
      sda_q <= b;
      w(8);
    end
  endtask
  task xfer(input [7:0] d, output [7:0] g, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], r);
        g[i] = r;
      end
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
  task xact(input rw, input [7:0] off, input [7:0] d, output [7:0] q, output ok);
    reg a0, a1, a2;
    begin
      frame(1'b1, 1'b0);
      xfer({ADDR, 1'b0}, q, a0);
      xfer(off, q, a1);
      if (rw) begin
        frame(1'b1, 1'b0);
        xfer({ADDR, 1'b1}, q, a2);
        // All ones leaves the line to the target; the ninth bit refuses more
        xfer(8'hff, q, ok);
      end else
        xfer(d, q, a2);
      frame(1'b0, 1'b1);
      ok = a0 & a1 & a2;
    end
  endtask
endmodule

//--- bench/redriver_global_config_bench.sv
// Self-checking bench for the global configuration registers
`timescale 1ns/1ps
`include "redriver_global_config_regs.vh"
module redriver_global_config_bench;
  reg        clk, arst_n, soft_reset, hpd, snp, wrt, ov, eqz, ok;
  reg  [7:0] q;
  wire       scl, sda, sda_oe, ho_pin, ho_oe, swp, rte, snpe, lin, cpl, deq, ceq, byp;
  wire [2:0] les, hes, ces;
  wire [1:0] dcg, txl;
  integer    mem [0:4];
  integer    n_errors, checks_done, seed, i, c;
  redriver_global_config uut (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .soft_reset(soft_reset), .hotplug_in_pin(hpd), .hotplug_out_pin(ho_pin), .hotplug_out_oe(ho_oe),
    .link_high_rate_snooped(snp), .link_high_rate_written(wrt), .tmds_clk_over_225(ov),
    .eq_setting_zero(eqz), .lane_swap(swp), .rx_term_enable(rte), .snoop_enable(snpe),
    .low_rate_edge_speed(les), .high_rate_edge_speed(hes), .clock_edge_speed(ces),
    .linear_style_select(lin), .tx_coupling_select(cpl), .dc_gain_level(dcg), .tx_load(txl),
    .data_eq_high_rate(deq), .clock_eq_high_rate(ceq), .equalizer_bypass(byp));
  i2c_host_model host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_line(sda));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task model_reset;
    begin
      mem[0] = `MISC_SETTINGS_RST;
      mem[1] = `DATA_SLEW_RST;
      mem[2] = `CLOCK_SLEW_RST;
      mem[3] = `DRIVE_SETTINGS_RST;
      mem[4] = `EQ_CHOICE_RST;
    end
  endtask
  task wr(input integer r, input [7:0] d);
    begin
      host.xact(1'b0, 8'h0a + r[7:0], d, q, ok);
      chk(ok, 8'h01);
      if (r == 1)
        mem[1] = d & `DATA_SLEW_WMASK;
      else if (r == 2)
        mem[2] = d & `CLOCK_SLEW_WMASK;
      else if (r < 5)
        mem[r] = d;
    end
  endtask
  task rd(input integer r);
    begin
      host.xact(1'b1, 8'h0a + r[7:0], 8'h00, q, ok);
      chk(ok, 8'h01);
      chk(q, r < 5 ? mem[r] : 0);
    end
  endtask
  task outs;
    integer m0, m1, m3, m4, g, t, rate, pick;
    begin
      m0 = mem[0];
      m1 = mem[1];
      m3 = mem[3];
      m4 = mem[4];
      rate = m0[2] ? wrt : snp;
      chk(swp, m0[7]);
      chk(snpe, !m0[2]);
      chk(rte, ~m0[5] & hpd);
      chk({ho_oe, ho_pin}, m0[4] ? {~hpd, 1'b0} : {1'b1, hpd});
      chk(les, m1[6:4]);
      chk(hes, m1[2:0]);
      chk(ces, mem[2] & 7);
      chk({lin, cpl}, m3[7:6]);
      g = m3[5:4];
      chk(dcg, g == 1 ? 0 : g);
      t = m3[1:0];
      if (t == 2)
        t = rate | m3[3] | ov;
      chk(txl, t);
      chk(byp, m3[2] & (g == 2) & eqz);
      pick = rate ? m4[3:2] : m4[5:4];
      chk(deq, (pick == 1) | ((pick == 2) & snp));
      chk(ceq, 8'h00);
    end
  endtask
  task stim;
    begin
      @(posedge clk);
      {hpd, snp, wrt, ov, eqz} <= $random(seed);
      repeat (6) @(posedge clk);
      outs;
    end
  endtask
  task tally_and_finish;
    begin
      if (n_errors == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors = n_errors + 1;
    tally_and_finish;
  end
  initial begin
    seed = 73;
    n_errors = 0;
    checks_done = 0;
    {arst_n, soft_reset, hpd, snp, wrt, ov, eqz} = 7'h00;
    model_reset;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    outs;
    for (i = 0; i < 6; i = i + 1)
      rd(i);
    // Open drain, snooping off, reserved bit 3 kept at its default
    wr(0, 8'h1c);
    for (i = 0; i < 3; i = i + 1)
      stim;
    for (c = 0; c < 4; c = c + 1) begin
      wr(3, ($random(seed) & 8'hc8) | 8'h04 | (c << 4) | c);
      wr(4, ($random(seed) & 8'hc3) | (c << 4) | (c << 2));
      for (i = 0; i < 4; i = i + 1)
        stim;
    end
    for (i = 0; i < 16; i = i + 1) begin
      c = {$random(seed)} % 6;
      wr(c, $random(seed));
      stim;
      rd(c);
    end
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    model_reset;
    repeat (3) @(posedge clk);
    outs;
    for (i = 0; i < 5; i = i + 1)
      rd(i);
    tally_and_finish;
  end
endmodule
